// file: common/lahp_pkg.sv
// package for the legacy audio host port register bank
package lahp_pkg;
    localparam int ADDR_W = 16;
    localparam int DECODE_W = 10;
    localparam logic [3:0] OFF_FM_L_SEL = 4'h0;
    localparam logic [3:0] OFF_FM_L_DATA = 4'h1;
    localparam logic [3:0] OFF_FM_R_SEL = 4'h2;
    localparam logic [3:0] OFF_FM_R_DATA = 4'h3;
    localparam logic [3:0] OFF_MIX_INDEX = 4'h4;
    localparam logic [3:0] OFF_MIX_DATA = 4'h5;
    localparam logic [3:0] OFF_SOFT_RESET = 4'h6;
    localparam logic [3:0] OFF_FM_SEL = 4'h8;
    localparam logic [3:0] OFF_FM_DATA = 4'h9;
    localparam logic [3:0] OFF_READ_DATA = 4'ha;
    localparam logic [3:0] OFF_CMD = 4'hc;
    localparam logic [3:0] OFF_AVAIL = 4'he;
    localparam logic [7:0] MIX_RESET = 8'h00;
    localparam logic [7:0] MIX_VOICE = 8'h04;
    localparam logic [7:0] MIX_MIC = 8'h0a;
    localparam logic [7:0] MIX_INSEL = 8'h0c;
    localparam logic [7:0] MIX_OUTCTL = 8'h0e;
    localparam logic [7:0] MIX_MASTER = 8'h22;
    localparam logic [7:0] MIX_FM = 8'h26;
    localparam logic [7:0] MIX_CD = 8'h28;
    localparam logic [7:0] MIX_LINE = 8'h2e;
    localparam logic [7:0] RST_VOICE = 8'h99;
    localparam logic [7:0] RST_MIC = 8'h01;
    localparam logic [7:0] RST_INSEL = 8'h00;
    localparam logic [7:0] RST_OUTCTL = 8'h00;
    localparam logic [7:0] RST_MASTER = 8'h99;
    localparam logic [7:0] RST_FM = 8'h99;
    localparam logic [7:0] RST_CD = 8'h01;
    localparam logic [7:0] RST_LINE = 8'h01;
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;
    localparam int STATUS_BIT = 7;
    localparam int SOFT_RESET_BIT = 0;
    localparam int STEREO_BIT = 1;

    typedef struct packed {
        logic [7:0] voice;
        logic [7:0] mic;
        logic [7:0] insel;
        logic [7:0] outctl;
        logic [7:0] master;
        logic [7:0] fm;
        logic [7:0] cd;
        logic [7:0] line;
    } lahp_mixer_t;

    // host-bus access presented to the block, one cycle per strobe
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } lahp_io_t;

    // pass-through access toward the fm synthesizer
    typedef struct packed {
        logic [1:0] bank;
        logic data_sel;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } lahp_fm_t;
endpackage

// file: hw/lahp_ports.sv
// host-visible register window of the legacy audio compatibility interface
`timescale 1ns/10ps
//
// How it works
// - decode ten address bits, upper bits zero
// - sixteen-location window at configured base
// - offsets zero to three pass to fm
// - offset four write-only mixer index
// - offset five reads/writes indexed mixer register
// - reset on reset-port bit0 one then zero
// - read port valid while offset E bit7
// - offset C writes go to command processor
// - offset C bit7 shows command ready
// - mixer index zero write restores defaults
// - index 04h voice volume, default 99h
// - index 0Ah mic level, default 01h
// - index 0Ch bits 2:1 pick adc input
// - index 0Eh bit1 mono or stereo
// - index 22h master volume, default 99h
// - index 26h fm volume, default 99h
// - index 28h cd volume, default 01h
// - index 2Eh line volume, default 01h
// - shared irq and dma follow active interface
// - mode switch needs no host sequence
module lahp_ports
    import lahp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic [15:0] compat_io_base_i,
    input wire lahp_io_t io_i,
    input wire logic [7:0] fm_rdata_i,
    input wire logic cmd_ready_i,
    input wire logic [7:0] result_data_i,
    input wire logic result_valid_i,
    input wire logic native_codec_active_i,
    input wire logic codec_irq_i,
    input wire logic codec_play_drq_i,
    input wire logic compat_play_dack_i,
    input wire logic native_play_dack_i,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    output lahp_fm_t fm_o,
    output logic [7:0] cmd_data_o,
    output logic cmd_write_o,
    output logic result_read_o,
    output logic compat_reset_o,
    output lahp_mixer_t mixer_o,
    output logic [1:0] adc_source_o,
    output logic stereo_output_select_o,
    output logic compat_irq_o,
    output logic native_irq_o,
    output logic compat_play_drq_o,
    output logic native_play_drq_o,
    output logic play_dack_o
);
    if (DECODE_W != 10 || ADDR_W != 16) begin : g_bad_widths
        $error("lahp_ports: decode widths not supported");
    end

    lahp_mixer_t mix_q;
    lahp_mixer_t mix_d;
    logic [7:0] index_q;
    logic soft_arm_q;

    // decode: window hits only with the upper address bits at zero
    wire addr_low10 = (io_i.addr[15:10] == 6'h00);
    wire base_hit = (io_i.addr[9:4] == compat_io_base_i[9:4]);
    wire hit = enable_i && addr_low10 && base_hit && !native_codec_active_i;
    wire [3:0] off = io_i.addr[3:0];
    wire wr = hit && io_i.wr;
    wire rd = hit && io_i.rd;

    wire fm_lr = (off[3:2] == 2'b00);
    wire fm_mono = (off[3:1] == 3'b100);
    wire fm_hit = fm_lr || fm_mono;
    wire idx_wr = wr && (off == OFF_MIX_INDEX);
    wire mix_wr = wr && (off == OFF_MIX_DATA);
    wire rst_wr = wr && (off == OFF_SOFT_RESET);
    wire cmd_wr = wr && (off == OFF_CMD);
    wire res_rd = rd && (off == OFF_READ_DATA);
    wire mix_default = mix_wr && (index_q == MIX_RESET);

    // soft reset fires on the falling write of bit 0
    wire soft_fire = rst_wr && soft_arm_q && !io_i.wdata[SOFT_RESET_BIT];
    wire any_rst = sys_rst_i || soft_fire;

    function automatic lahp_mixer_t mix_defaults();
        lahp_mixer_t m;
        m.voice = RST_VOICE;
        m.mic = RST_MIC;
        m.insel = RST_INSEL;
        m.outctl = RST_OUTCTL;
        m.master = RST_MASTER;
        m.fm = RST_FM;
        m.cd = RST_CD;
        m.line = RST_LINE;
        return m;
    endfunction

    function automatic logic [7:0] mix_read(input logic [7:0] idx, input lahp_mixer_t m);
        case (idx)
            MIX_VOICE: mix_read = m.voice;
            MIX_MIC: mix_read = {5'h00, m.mic[2:0]};
            MIX_INSEL: mix_read = {5'h00, m.insel[2:1], 1'b0};
            MIX_OUTCTL: mix_read = {6'h00, m.outctl[STEREO_BIT], 1'b0};
            MIX_MASTER: mix_read = m.master;
            MIX_FM: mix_read = m.fm;
            MIX_CD: mix_read = m.cd;
            MIX_LINE: mix_read = m.line;
            default: mix_read = UNMAPPED_READ;
        endcase
    endfunction

    always_comb begin
        mix_d = mix_q;
        if (mix_default) begin
            mix_d = mix_defaults();
        end else if (mix_wr) begin
            case (index_q)
                MIX_VOICE: mix_d.voice = io_i.wdata;
                MIX_MIC: mix_d.mic = {5'h00, io_i.wdata[2:0]};
                MIX_INSEL: mix_d.insel = {5'h00, io_i.wdata[2:1], 1'b0};
                MIX_OUTCTL: mix_d.outctl = {6'h00, io_i.wdata[STEREO_BIT], 1'b0};
                MIX_MASTER: mix_d.master = io_i.wdata;
                MIX_FM: mix_d.fm = io_i.wdata;
                MIX_CD: mix_d.cd = io_i.wdata;
                MIX_LINE: mix_d.line = io_i.wdata;
                default: mix_d = mix_q;
            endcase
        end
    end

    wire [7:0] mix_rdata = mix_read(index_q, mix_q);
    wire [7:0] cmd_status = {cmd_ready_i, 7'h7f};
    wire [7:0] avail_status = {result_valid_i, 7'h7f};
    wire [7:0] rd_mux =
        fm_hit ? fm_rdata_i :
        (off == OFF_MIX_DATA) ? mix_rdata :
        (off == OFF_READ_DATA) ? result_data_i :
        (off == OFF_CMD) ? cmd_status :
        (off == OFF_AVAIL) ? avail_status :
        UNMAPPED_READ;

    always_ff @(posedge ref_clk_i) begin
        if (any_rst) begin
            mix_q <= mix_defaults();
            index_q <= RST_INDEX;
        end else begin
            mix_q <= mix_d;
            if (idx_wr) begin
                index_q <= io_i.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            soft_arm_q <= 1'b0;
            compat_reset_o <= 1'b0;
        end else begin
            if (rst_wr) begin
                soft_arm_q <= io_i.wdata[SOFT_RESET_BIT];
            end
            compat_reset_o <= soft_fire;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
            rdata_valid_o <= 1'b0;
            fm_o <= '0;
            cmd_data_o <= 8'h00;
            cmd_write_o <= 1'b0;
            result_read_o <= 1'b0;
        end else begin
            rdata_valid_o <= rd;
            if (rd) begin
                rdata_o <= rd_mux;
            end
            fm_o.rd <= rd && fm_hit;
            fm_o.wr <= wr && fm_hit;
            fm_o.bank <= fm_mono ? 2'b10 : {1'b0, off[1]};
            fm_o.data_sel <= off[0];
            fm_o.wdata <= io_i.wdata;
            cmd_write_o <= cmd_wr;
            if (cmd_wr) begin
                cmd_data_o <= io_i.wdata;
            end
            result_read_o <= res_rd;
        end
    end

    // the mixer view leaves the block registered
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mixer_o <= mix_defaults();
            adc_source_o <= 2'b00;
            stereo_output_select_o <= 1'b0;
        end else begin
            mixer_o <= mix_q;
            adc_source_o <= mix_q.insel[2:1];
            stereo_output_select_o <= mix_q.outctl[STEREO_BIT];
        end
    end

    // one codec irq and dma channel steered with the active interface, no host step
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            compat_irq_o <= 1'b0;
            native_irq_o <= 1'b0;
            compat_play_drq_o <= 1'b0;
            native_play_drq_o <= 1'b0;
            play_dack_o <= 1'b0;
        end else begin
            compat_irq_o <= codec_irq_i && !native_codec_active_i;
            native_irq_o <= codec_irq_i && native_codec_active_i;
            compat_play_drq_o <= codec_play_drq_i && !native_codec_active_i;
            native_play_drq_o <= codec_play_drq_i && native_codec_active_i;
            play_dack_o <= native_codec_active_i ? native_play_dack_i : compat_play_dack_i;
        end
    end

    a_alias_refused: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (io_i.wr && io_i.addr[15:10] != 6'h00) |=> !cmd_write_o && !fm_o.wr)
        else $error("aliased address was decoded");

    a_index_held: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!idx_wr && !any_rst) |=> index_q == $past(index_q))
        else $error("mixer index changed without a write");

    a_index_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (idx_wr && !soft_fire) |=> index_q == $past(io_i.wdata))
        else $error("mixer index not taken");

    a_mixer_defaults: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        mix_default |=> mix_q.voice == 8'h99 && mix_q.cd == 8'h01 && mix_q.master == 8'h99)
        else $error("mixer defaults not restored");

    a_soft_reset: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rst_wr && soft_arm_q && !io_i.wdata[SOFT_RESET_BIT]) |=> compat_reset_o)
        else $error("soft reset did not fire");

    a_cmd_forward: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        cmd_wr |=> cmd_write_o && cmd_data_o == $past(io_i.wdata))
        else $error("command write lost");

    a_ready_status: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd && off == OFF_CMD) |=> rdata_valid_o && rdata_o[7] == $past(cmd_ready_i))
        else $error("write buffer status wrong");

    a_avail_status: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd && off == OFF_AVAIL) |=> rdata_o[7] == $past(result_valid_i))
        else $error("data available status wrong");

    a_stereo_out: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (mix_wr && index_q == MIX_OUTCTL && !soft_fire) |=> ##1
            stereo_output_select_o == $past(io_i.wdata[1], 2))
        else $error("stereo select not applied");

    a_irq_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (codec_irq_i && native_codec_active_i) |=> native_irq_o && !compat_irq_o)
        else $error("codec irq misrouted");

    a_alias_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (io_i.rd && io_i.addr[15:10] != 6'h00) |=>
        !rdata_valid_o && !fm_o.rd)
        else $error("aliased read was decoded");

    a_base_miss: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ((io_i.rd || io_i.wr) && io_i.addr[9:4] != compat_io_base_i[9:4]) |=>
        !rdata_valid_o && !cmd_write_o && !fm_o.wr)
        else $error("access outside the window was decoded");

    a_window_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (io_i.rd && enable_i && !native_codec_active_i &&
        io_i.addr[15:4] == {6'h00, compat_io_base_i[9:4]}) |=> rdata_valid_o)
        else $error("window read not decoded");

    a_disabled_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !enable_i |=>
        !rdata_valid_o && !cmd_write_o && !fm_o.wr && !fm_o.rd)
        else $error("disabled window answered");

    a_fm_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr && fm_hit) |=>
        fm_o.wr && fm_o.wdata == $past(io_i.wdata))
        else $error("fm write not passed on");

    a_fm_bank: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr && off[3:2] == 2'b00) |=>
        fm_o.bank == {1'b0, $past(off[1])} && fm_o.data_sel == $past(off[0]))
        else $error("fm side or port wrong");

    a_fm_mono: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr && off[3:1] == 3'b100) |=>
        fm_o.bank == 2'b10 && fm_o.data_sel == $past(off[0]))
        else $error("fm mono port wrong");

    a_fm_read_data: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd && fm_hit) |=>
        fm_o.rd && rdata_o == $past(fm_rdata_i))
        else $error("fm status read wrong");

    a_voice_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (mix_wr && index_q == MIX_VOICE) |=>
        mix_q.voice == $past(io_i.wdata))
        else $error("voice volume not stored");

    a_master_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (mix_wr && index_q == MIX_MASTER) |=>
        mix_q.master == $past(io_i.wdata))
        else $error("master volume not stored");

    a_fm_volume: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (mix_wr && index_q == MIX_FM) |=>
        mix_q.fm == $past(io_i.wdata))
        else $error("fm volume not stored");

    a_line_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (mix_wr && index_q == MIX_LINE) |=>
        mix_q.line == $past(io_i.wdata))
        else $error("line volume not stored");

    a_mixer_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd && off == OFF_MIX_DATA && index_q == MIX_MASTER) |=>
        rdata_o == $past(mix_q.master))
        else $error("indexed mixer read wrong");

    a_reserved_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (mix_wr && index_q == 8'h02) |=>
        mix_q == $past(mix_q))
        else $error("reserved mixer write took effect");

    a_adc_source: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (mix_wr && index_q == MIX_INSEL) |=> ##1
        adc_source_o == $past(io_i.wdata[2:1], 2))
        else $error("converter source not applied");

    a_outctl_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd && off == OFF_MIX_DATA && index_q == MIX_OUTCTL) |=>
        rdata_o[7:2] == 6'h00 && rdata_o[0] == 1'b0)
        else $error("output control read shows stray bits");

    a_result_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd && off == OFF_READ_DATA) |=>
        result_read_o && rdata_o == $past(result_data_i))
        else $error("read data port wrong");

    a_soft_restores: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        soft_fire |=>
        index_q == RST_INDEX && mix_q == mix_defaults())
        else $error("soft reset left mixer state");

    a_soft_armless: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rst_wr && !soft_arm_q) |=>
        !compat_reset_o)
        else $error("soft reset without a prior one");

    a_drq_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (codec_play_drq_i && !native_codec_active_i) |=>
        compat_play_drq_o && !native_play_drq_o)
        else $error("playback request misrouted");

    a_compat_irq: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (codec_irq_i && !native_codec_active_i) |=>
        compat_irq_o && !native_irq_o)
        else $error("compat irq misrouted");

    a_native_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        native_codec_active_i |=>
        !rdata_valid_o && !cmd_write_o && !fm_o.wr)
        else $error("window answered in native mode");
endmodule

// file: verif/lahp_host.sv
// host model issuing single-cycle i/o strobes into the window
`timescale 1ns/10ps
module lahp_host
    import lahp_pkg::*;
(
    input wire logic clk_i,
    input wire logic [15:0] base_i,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_valid_i,
    output lahp_io_t io_o
);
    initial io_o = '{addr: 16'hffff, wdata: 8'h00, rd: 1'b0, wr: 1'b0};
    // idle bus shows inverted address and data so a stale decode cannot pass
    task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w,
                       output logic [7:0] q, output logic v);
        @(negedge clk_i);
        io_o = '{addr: a, wdata: d, rd: !w, wr: w};
        @(negedge clk_i);
        q = rdata_i;
        v = rdata_valid_i;
        io_o = '{addr: ~a, wdata: ~d, rd: 1'b0, wr: 1'b0};
    endtask
    task automatic wr(input logic [3:0] off, input logic [7:0] d);
        logic [7:0] q;
        logic v;
        cyc({base_i[15:4], off}, d, 1'b1, q, v);
    endtask
    task automatic rd(input logic [3:0] off, output logic [7:0] q, output logic v);
        cyc({base_i[15:4], off}, 8'h00, 1'b0, q, v);
    endtask
    task automatic mix_wr(input logic [7:0] idx, input logic [7:0] d);
        wr(OFF_MIX_INDEX, idx);
        wr(OFF_MIX_DATA, d);
    endtask
    task automatic mix_rd(input logic [7:0] idx, output logic [7:0] q);
        logic v;
        wr(OFF_MIX_INDEX, idx);
        rd(OFF_MIX_DATA, q, v);
    endtask
    // poll write-buffer status before sending a command
    task automatic cmd_wr(input logic [7:0] d);
        logic [7:0] q;
        logic v;
        q = 8'h00;
        for (int i = 0; i < 20 && q[7] !== 1'b1; i++) rd(OFF_CMD, q, v);
        wr(OFF_CMD, d);
    endtask
    task automatic soft_reset();
        wr(OFF_SOFT_RESET, 8'h01);
        wr(OFF_SOFT_RESET, 8'h00);
    endtask
endmodule

// file: verif/legacy_audio_host_ports_tb.sv
// self-checking bench for the legacy audio host port window
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module legacy_audio_host_ports_tb;
    import lahp_pkg::*;
    logic ref_clk_i = 0, sys_rst_i = 1, enable_i = 1, cmd_ready_i = 0, result_valid_i = 0;
    logic native_codec_active_i = 0, codec_irq_i = 0, codec_play_drq_i = 0;
    logic compat_play_dack_i = 0, native_play_dack_i = 0;
    logic [15:0] base = 16'h0220;
    logic [7:0] fm_rdata_i = 8'h00, result_data_i = 8'h00, rdata_o, cmd_data_o, q;
    logic [1:0] adc_source_o;
    logic rdata_valid_o, cmd_write_o, result_read_o, compat_reset_o, stereo_output_select_o;
    logic compat_irq_o, native_irq_o, compat_play_drq_o, native_play_drq_o, play_dack_o, v;
    lahp_io_t io;
    lahp_fm_t fm_o;
    lahp_mixer_t mixer_o;
    int failures = 0, n_tests = 0;
    localparam lahp_mixer_t DFLT = {8'h99, 8'h01, 8'h00, 8'h00, 8'h99, 8'h99, 8'h01, 8'h01};
    logic [7:0] idx [8] = '{8'h04, 8'h0a, 8'h0c, 8'h0e, 8'h22, 8'h26, 8'h28, 8'h2e};
    logic [7:0] msk [8] = '{8'hff, 8'h07, 8'h06, 8'h02, 8'hff, 8'hff, 8'hff, 8'hff};
    always #12.5 ref_clk_i = ~ref_clk_i;
    lahp_host host_u (.clk_i(ref_clk_i), .base_i(base), .rdata_i(rdata_o),
        .rdata_valid_i(rdata_valid_o), .io_o(io));
    lahp_ports dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
        .compat_io_base_i(base), .io_i(io), .fm_rdata_i(fm_rdata_i), .cmd_ready_i(cmd_ready_i),
        .result_data_i(result_data_i), .result_valid_i(result_valid_i),
        .native_codec_active_i(native_codec_active_i), .codec_irq_i(codec_irq_i),
        .codec_play_drq_i(codec_play_drq_i), .compat_play_dack_i(compat_play_dack_i),
        .native_play_dack_i(native_play_dack_i), .rdata_o(rdata_o),
        .rdata_valid_o(rdata_valid_o), .fm_o(fm_o), .cmd_data_o(cmd_data_o),
        .cmd_write_o(cmd_write_o), .result_read_o(result_read_o),
        .compat_reset_o(compat_reset_o), .mixer_o(mixer_o), .adc_source_o(adc_source_o),
        .stereo_output_select_o(stereo_output_select_o), .compat_irq_o(compat_irq_o),
        .native_irq_o(native_irq_o), .compat_play_drq_o(compat_play_drq_o),
        .native_play_drq_o(native_play_drq_o), .play_dack_o(play_dack_o));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_defaults();
        `CHK(mixer_o, DFLT)
        for (int i = 0; i < 8; i++) begin
            host_u.mix_rd(idx[i], q);
            `CHK(q, DFLT[63-8*i -: 8] & msk[i])
        end
        $display("defaults done");
    endtask
    task automatic t_rw();
        for (int i = 0; i < 8; i++) host_u.mix_wr(idx[i], 8'h5a + 8'(i));
        for (int i = 0; i < 8; i++) begin
            host_u.mix_rd(idx[i], q);
            `CHK(q, (8'h5a + 8'(i)) & msk[i])
            host_u.rd(OFF_MIX_DATA, q, v); // index still held
            `CHK(q, (8'h5a + 8'(i)) & msk[i])
        end
        for (int k = 0; k < 4; k++) begin
            host_u.mix_wr(MIX_INSEL, 8'(k << 1));
            host_u.mix_wr(MIX_OUTCTL, 8'(k << 1) & 8'h02);
            repeat (2) @(negedge ref_clk_i);
            `CHK(adc_source_o, 2'(k))
            `CHK(stereo_output_select_o, k[0])
        end
        $display("mixer access done");
    endtask
    task automatic t_mix_reset();
        lahp_mixer_t keep;
        keep = mixer_o;
        host_u.mix_wr(8'h02, 8'h3c);
        repeat (2) @(negedge ref_clk_i);
        `CHK(mixer_o, keep)
        host_u.mix_rd(8'h02, q);
        `CHK(q, UNMAPPED_READ)
        host_u.mix_wr(MIX_RESET, 8'ha5);
        repeat (2) @(negedge ref_clk_i);
        `CHK(mixer_o, DFLT)
        $display("mixer reset done");
    endtask
    task automatic t_fm_decode();
        logic [3:0] offs [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
        fm_rdata_i = 8'h3c;
        for (int i = 0; i < 6; i++) begin
            host_u.wr(offs[i], 8'h70 + 8'(i));
            `CHK({fm_o.wr, fm_o.bank, fm_o.data_sel, fm_o.wdata},
                {1'b1, offs[i][3] ? 2'd2 : {1'b0, offs[i][1]}, offs[i][0], 8'h70 + 8'(i)})
        end
        host_u.rd(OFF_FM_SEL, q, v);
        `CHK({fm_o.rd, v, q}, 10'h33c)
        host_u.cyc({6'h01, base[9:4], OFF_FM_L_SEL}, 8'h00, 1'b0, q, v);
        `CHK(v, 1'b0)
        host_u.cyc({6'h00, base[9:4] ^ 6'h01, OFF_FM_L_SEL}, 8'h00, 1'b0, q, v);
        `CHK(v, 1'b0)
        enable_i = 0;
        host_u.rd(OFF_FM_L_SEL, q, v);
        `CHK(v, 1'b0)
        enable_i = 1;
        $display("fm and decode done");
    endtask
    task automatic t_cmd();
        host_u.rd(OFF_CMD, q, v);
        `CHK(q[7], 1'b0)
        cmd_ready_i = 1;
        host_u.cmd_wr(8'hd1);
        `CHK({cmd_write_o, cmd_data_o}, 9'h1d1)
        result_valid_i = 1;
        result_data_i = 8'hc3;
        host_u.rd(OFF_AVAIL, q, v);
        `CHK(q[7], 1'b1)
        host_u.rd(OFF_READ_DATA, q, v);
        `CHK({result_read_o, q}, 9'h1c3)
        $display("command done");
    endtask
    task automatic t_soft();
        logic seen;
        seen = 0;
        host_u.mix_wr(MIX_MASTER, 8'h12);
        host_u.wr(OFF_SOFT_RESET, 8'h01);
        host_u.mix_rd(MIX_MASTER, q);
        `CHK(q, 8'h12)
        host_u.wr(OFF_SOFT_RESET, 8'h00);
        repeat (3) begin
            seen |= compat_reset_o === 1'b1;
            @(negedge ref_clk_i);
        end
        `CHK(seen, 1'b1)
        `CHK(mixer_o, DFLT)
        $display("soft reset done");
    endtask
    task automatic t_route();
        for (int m = 0; m < 2; m++) begin
            native_codec_active_i = m[0];
            {codec_irq_i, codec_play_drq_i, compat_play_dack_i, native_play_dack_i} =
                {2'b11, !m[0], m[0]};
            repeat (3) @(negedge ref_clk_i);
            `CHK({compat_irq_o, native_irq_o}, {!m[0], m[0]})
            `CHK({compat_play_drq_o, native_play_drq_o, play_dack_o}, {!m[0], m[0], 1'b1})
            host_u.rd(OFF_AVAIL, q, v);
            `CHK(v, !m[0])
        end
        native_codec_active_i = 0;
        $display("routing done");
    endtask
    initial begin
        #100000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (10) @(negedge ref_clk_i);
        sys_rst_i = 0;
        t_defaults();
        t_rw();
        t_mix_reset();
        t_fm_decode();
        t_cmd();
        t_soft();
        t_route();
        end_of_test();
    end
endmodule
